// *** design/sncr_node_regs.v ***
// Switch node configuration register bank
// Summary of operation
// - Registers reached only by configuration reads and writes by number.
// - Boot mode pins captured on the first edge after reset release, shown read-only in bits 17:16.
// - Identification read-only: chip id, switch revision, switch version.
// - Topology register read-only: links, cores, links per processor.
// - Security bit 31 set makes every configuration write rejected.
// - Security bit 8 set makes PLL settings writes ignored.
// - Security bit 0 selects one-byte packet headers; resets to 0.
`timescale 1ns/1ps
`include "sncr_defs.vh"
module sncr_node_regs #(
    parameter [7:0] CHIP_ID = 8'h5A,
    parameter [7:0] SW_REVISION = 8'h01,
    parameter [7:0] SW_VERSION = 8'h01,
    parameter [7:0] LINK_COUNT = 8'h08,
    parameter [7:0] CORE_COUNT = 8'h01,
    parameter [7:0] LINKS_PER_PROC = 8'h04,
    parameter [31:0] PLL_RST_VALUE = `SNCR_RST_PLL
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Boot mode pins
    input wire boot_select_pin_a,
    input wire boot_select_pin_b,
    // Configuration transaction port
    input wire cfg_rd,
    input wire cfg_wr,
    input wire [7:0] cfg_num,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata_q,
    output reg cfg_rvalid_q,
    output reg cfg_wack_q,
    output reg cfg_werr_q,
    // Configuration outputs to the switch
    output wire one_byte_headers,
    output wire pll_locked,
    output wire [15:0] route_id,
    output wire [31:0] pll_settings,
    output reg pll_write_pulse_q,
    output wire [15:0] switch_clock_div,
    output wire [15:0] reference_clock_div,
    output wire [63:0] route_directions,
    output wire [1:0] debug_pin_cfg
);
    ////////////////////////////////////////////////////////////////////
    // Decode helpers
    function is_array;
        input [7:0] num;
        begin
            is_array = ((num & 8'hF8) == `SNCR_REG_LINK_BASE) ||
                ((num & 8'hFC) == `SNCR_REG_PROCESSOR_LINK_BASE) ||
                ((num & 8'hF8) == `SNCR_REG_LSETUP_BASE) ||
                ((num & 8'hF8) == `SNCR_REG_LFIXED_BASE);
        end
    endfunction

    function [4:0] array_slot;
        input [7:0] num;
        begin
            array_slot = {num[7:5] == 3'b101 ? 2'b11 :
                num[7] ? 2'b10 : num[6] ? 2'b01 : 2'b00, num[2:0]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registers
    reg [1:0] boot_pins_q;
    reg boot_cap_q;
    reg wr_lock_q;
    reg pll_lock_q;
    reg hdr_mode_q;
    reg [31:0] route_id_q;
    reg [31:0] pll_q;
    reg [31:0] sw_clk_q;
    reg [31:0] ref_clk_q;
    reg [31:0] dir_low_q;
    reg [31:0] dir_high_q;
    reg [31:0] dbg_pin_q;
    reg [31:0] dbg_origin_q;
    reg rd_arr_q;
    wire [31:0] arr_rdata;
    wire wr_ok;
    wire arr_wr;
    wire [31:0] sec_word;

    assign wr_ok = cfg_wr && !wr_lock_q;
    assign arr_wr = wr_ok && is_array(cfg_num);
    assign sec_word = {wr_lock_q, 22'h0, pll_lock_q, 7'h00,
        hdr_mode_q};

    // Boot pins sampled on the first edge after reset release
    always @(posedge clk) begin
        if (!rst_n) begin
            boot_pins_q <= 2'b00;
            boot_cap_q <= 1'b0;
        end else if (!boot_cap_q) begin
            boot_pins_q <= {boot_select_pin_b, boot_select_pin_a};
            boot_cap_q <= 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            wr_lock_q <= 1'b0;
            pll_lock_q <= 1'b0;
            hdr_mode_q <= 1'b0;
            route_id_q <= `SNCR_RST_ROUTE_ID;
            pll_q <= PLL_RST_VALUE & `SNCR_MASK_PLL;
            sw_clk_q <= `SNCR_RST_SW_CLK;
            ref_clk_q <= `SNCR_RST_REF_CLK;
            dir_low_q <= `SNCR_RST_DIR;
            dir_high_q <= `SNCR_RST_DIR;
            dbg_pin_q <= 32'h00000000;
            dbg_origin_q <= 32'h00000000;
            pll_write_pulse_q <= 1'b0;
        end else begin
            pll_write_pulse_q <= 1'b0;
            if (wr_ok) begin
                if (cfg_num == `SNCR_REG_SEC_HDR) begin
                    // Lock bit is sticky until reset
                    wr_lock_q <= wr_lock_q |
                        cfg_wdata[`SNCR_SEC_WR_LOCK_BIT];
                    pll_lock_q <= cfg_wdata[`SNCR_SEC_PLL_LOCK_BIT];
                    hdr_mode_q <= cfg_wdata[`SNCR_SEC_HDR_BIT];
                end else if (cfg_num == `SNCR_REG_ROUTE_ID) begin
                    route_id_q <= cfg_wdata & `SNCR_MASK_ROUTE_ID;
                end else if (cfg_num == `SNCR_REG_PLL_RATIO) begin
                    if (!pll_lock_q) begin
                        pll_q <= cfg_wdata & `SNCR_MASK_PLL;
                        pll_write_pulse_q <= 1'b1;
                    end
                end else if (cfg_num == `SNCR_REG_SW_CLK) begin
                    sw_clk_q <= cfg_wdata & `SNCR_MASK_SW_CLK;
                end else if (cfg_num == `SNCR_REG_REF_CLK) begin
                    ref_clk_q <= cfg_wdata & `SNCR_MASK_REF_CLK;
                end else if (cfg_num == `SNCR_REG_DIR_LOW) begin
                    dir_low_q <= cfg_wdata;
                end else if (cfg_num == `SNCR_REG_DIR_HIGH) begin
                    dir_high_q <= cfg_wdata;
                end else if (cfg_num == `SNCR_REG_DBG_PIN) begin
                    dbg_pin_q <= cfg_wdata & `SNCR_MASK_DBG_PIN;
                end else if (cfg_num == `SNCR_REG_DBG_ORIGIN) begin
                    dbg_origin_q <= cfg_wdata & `SNCR_MASK_DBG_ORIGIN;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link register groups
    sncr_array_mem #(
        .DEPTH(`SNCR_ARR_SLOTS),
        .AW(`SNCR_ARR_AW),
        .DW(32)
    ) u_arr (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(arr_wr),
        .wr_addr(array_slot(cfg_num)),
        .wr_data(cfg_wdata),
        .rd_addr(array_slot(cfg_num)),
        .rd_data_q(arr_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Read path, write answer
    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h00000000;
        if (cfg_num == `SNCR_REG_NODE_IDENT) begin
            rd_word = {CHIP_ID, 6'h00, boot_pins_q, SW_REVISION,
                SW_VERSION};
        end else if (cfg_num == `SNCR_REG_TOPO_INFO) begin
            rd_word = {8'h00, LINK_COUNT, CORE_COUNT,
                LINKS_PER_PROC};
        end else if (cfg_num == `SNCR_REG_SEC_HDR) begin
            rd_word = sec_word;
        end else if (cfg_num == `SNCR_REG_ROUTE_ID) begin
            rd_word = route_id_q;
        end else if (cfg_num == `SNCR_REG_PLL_RATIO) begin
            rd_word = pll_q;
        end else if (cfg_num == `SNCR_REG_SW_CLK) begin
            rd_word = sw_clk_q;
        end else if (cfg_num == `SNCR_REG_REF_CLK) begin
            rd_word = ref_clk_q;
        end else if (cfg_num == `SNCR_REG_DIR_LOW) begin
            rd_word = dir_low_q;
        end else if (cfg_num == `SNCR_REG_DIR_HIGH) begin
            rd_word = dir_high_q;
        end else if (cfg_num == `SNCR_REG_DBG_PIN) begin
            rd_word = dbg_pin_q;
        end else if (cfg_num == `SNCR_REG_DBG_ORIGIN) begin
            rd_word = dbg_origin_q;
        end
    end

    reg [31:0] rd_hold_q;
    reg rd_pend_q;
    always @(posedge clk) begin
        if (!rst_n) begin
            rd_hold_q <= 32'h00000000;
            rd_pend_q <= 1'b0;
            rd_arr_q <= 1'b0;
            cfg_rdata_q <= 32'h00000000;
            cfg_rvalid_q <= 1'b0;
            cfg_wack_q <= 1'b0;
            cfg_werr_q <= 1'b0;
        end else begin
            rd_pend_q <= cfg_rd && !cfg_wr;
            rd_arr_q <= is_array(cfg_num);
            rd_hold_q <= rd_word;
            cfg_rvalid_q <= rd_pend_q;
            if (rd_pend_q) begin
                cfg_rdata_q <= rd_arr_q ? arr_rdata : rd_hold_q;
            end
            cfg_wack_q <= cfg_wr;
            cfg_werr_q <= cfg_wr && wr_lock_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign one_byte_headers = hdr_mode_q;
    assign pll_locked = pll_lock_q;
    assign route_id = route_id_q[15:0];
    assign pll_settings = pll_q;
    assign switch_clock_div = sw_clk_q[15:0];
    assign reference_clock_div = ref_clk_q[15:0];
    assign route_directions = {dir_high_q, dir_low_q};
    assign debug_pin_cfg = dbg_pin_q[1:0];
endmodule // sncr_node_regs

// *** design/sncr_defs.vh ***
// Constants of the switch node configuration register bank
`ifndef SNCR_DEFS_VH
`define SNCR_DEFS_VH

// Register numbers
`define SNCR_REG_NODE_IDENT 8'h00
`define SNCR_REG_TOPO_INFO 8'h01
`define SNCR_REG_SEC_HDR 8'h04
`define SNCR_REG_ROUTE_ID 8'h05
`define SNCR_REG_PLL_RATIO 8'h06
`define SNCR_REG_SW_CLK 8'h07
`define SNCR_REG_REF_CLK 8'h08
`define SNCR_REG_DIR_LOW 8'h0C
`define SNCR_REG_DIR_HIGH 8'h0D
`define SNCR_REG_DBG_PIN 8'h10
`define SNCR_REG_DBG_ORIGIN 8'h1F
`define SNCR_REG_LINK_BASE 8'h20
`define SNCR_REG_PROCESSOR_LINK_BASE 8'h40
`define SNCR_REG_LSETUP_BASE 8'h80
`define SNCR_REG_LFIXED_BASE 8'hA0

// Switch security and header fields
`define SNCR_SEC_WR_LOCK_BIT 31
`define SNCR_SEC_PLL_LOCK_BIT 8
`define SNCR_SEC_HDR_BIT 0

// Field masks of writable registers
`define SNCR_MASK_SEC 32'h80000101
`define SNCR_MASK_ROUTE_ID 32'h0000FFFF
`define SNCR_MASK_PLL 32'h039FFF7F
`define SNCR_MASK_SW_CLK 32'h0000FFFF
`define SNCR_MASK_REF_CLK 32'h0000FFFF
`define SNCR_MASK_DBG_PIN 32'h00000003
`define SNCR_MASK_DBG_ORIGIN 32'h00000011

// Reset values
`define SNCR_RST_ROUTE_ID 32'h00000000
`define SNCR_RST_SW_CLK 32'h00000000
`define SNCR_RST_REF_CLK 32'h00000003
`define SNCR_RST_DIR 32'h00000000
`define SNCR_RST_PLL 32'h00000000

// Register array slots
`define SNCR_ARR_SLOTS 32
`define SNCR_ARR_AW 5

`endif

// *** design/sncr_array_mem.v ***
// Small register memory for the link register groups
`timescale 1ns/1ps
module sncr_array_mem #(
    parameter DEPTH = 32,
    parameter AW = 5,
    parameter DW = 32
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Write port
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    // Read port
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data_q
);
    reg [DW-1:0] mem_q [0:DEPTH-1];
    integer i;

    always @(posedge clk) begin
        if (!rst_n) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {DW{1'b0}};
            end
            rd_data_q <= {DW{1'b0}};
        end else begin
            if (wr_en) begin
                mem_q[wr_addr] <= wr_data;
            end
            rd_data_q <= mem_q[rd_addr];
        end
    end
endmodule // sncr_array_mem

// *** bench/sncr_node_regs_assertions.sv ***
// Port checker of the node register bank
`timescale 1ns/1ps
module sncr_chk (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Configuration port
    input wire cfg_rd,
    input wire cfg_wr,
    input wire [7:0] cfg_num,
    input wire [31:0] cfg_rdata_q,
    input wire cfg_rvalid_q,
    input wire cfg_wack_q,
    input wire cfg_werr_q,
    // Switch side
    input wire one_byte_headers,
    input wire pll_locked,
    input wire [15:0] route_id,
    input wire [31:0] pll_settings
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////
    property p_rd_lat;
        cfg_rd && !cfg_wr |-> !cfg_rvalid_q ##1 !cfg_rvalid_q ##1 cfg_rvalid_q;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read late");
    property p_wack;
        cfg_wack_q == $past(cfg_wr);
    endproperty
    a_wack: assert property (p_wack) else $error("write ack");
    property p_werr;
        cfg_werr_q |-> cfg_wack_q && $stable(route_id) && $stable(pll_settings);
    endproperty
    a_werr: assert property (p_werr) else $error("locked write");
    property p_sticky;
        cfg_werr_q ##1 cfg_wr |=> cfg_werr_q;
    endproperty
    a_sticky: assert property (p_sticky) else $error("lock lost");
    property p_pll;
        pll_locked && cfg_wr && cfg_num == 8'h06 |=>
            $stable(pll_settings) && !cfg_werr_q;
    endproperty
    a_pll: assert property (p_pll) else $error("pll updated");
    property p_rst;
        $rose(rst_n) |-> !one_byte_headers && !pll_locked && route_id == 16'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_hdr;
        $changed(one_byte_headers) |-> $past(cfg_wr) && $past(cfg_num) == 8'h04;
    endproperty
    a_hdr: assert property (p_hdr) else $error("header mode");
    property p_topo;
        cfg_rvalid_q && $past(cfg_num) == 8'h01 |-> cfg_rdata_q[31:24] == 8'h0;
    endproperty
    a_topo: assert property (p_topo) else $error("reserved bits");
endmodule // sncr_chk

// *** bench/sncr_cfg_requester.sv ***
// Requester model issuing configuration reads and writes
`timescale 1ns/1ps
module sncr_cfg_requester (
    // Clock
    input wire clk,
    // Requests
    output reg cfg_rd = 1'b0,
    output reg cfg_wr = 1'b0,
    output reg [7:0] cfg_num = 8'h00,
    output reg [31:0] cfg_wdata = 32'h0,
    // Answers
    input wire [31:0] cfg_rdata_q,
    input wire cfg_rvalid_q,
    input wire cfg_wack_q,
    input wire cfg_werr_q
);
    // One pulse request by register number, then a bounded wait
    task xfer(input w, input [7:0] n, input [31:0] d,
              output [31:0] q, output e);
        integer i;
        begin
            @(posedge clk);
            cfg_rd <= !w;
            cfg_wr <= w;
            cfg_num <= n;
            cfg_wdata <= d;
            @(posedge clk);
            cfg_rd <= 1'b0;
            cfg_wr <= 1'b0;
            cfg_num <= ~n;
            cfg_wdata <= ~d;
            i = 0;
            #1;
            while (i < 4 && !(w ? cfg_wack_q : cfg_rvalid_q)) begin
                @(posedge clk);
                #1;
                i = i + 1;
            end
            q = cfg_rdata_q;
            e = cfg_werr_q;
        end
    endtask
endmodule // sncr_cfg_requester

// *** bench/switch_node_config_regs_tb_top.sv ***
// Testbench of the node register bank
`timescale 1ns/1ps
module switch_node_config_regs_tb_top;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg boot_select_pin_a = 1'b1;
    reg boot_select_pin_b = 1'b0;
    wire cfg_rd, cfg_wr, cfg_rvalid_q, cfg_wack_q, cfg_werr_q;
    wire one_byte_headers, pll_locked;
    wire [7:0] cfg_num;
    wire [15:0] route_id;
    wire [31:0] cfg_wdata, cfg_rdata_q, pll_settings;
    wire [63:0] route_directions;
    wire pll_wr_pulse;
    wire [15:0] sw_div, ref_div;
    wire [1:0] dbg_cfg;
    reg [31:0] q;
    reg e;
    integer errors = 0;
    integer checks = 0;
    integer cyc = 0;
    always #25 clk = ~clk;
    // Chip id value is arbitrary
    sncr_node_regs #(.CHIP_ID(8'h3C), .LINK_COUNT(8'h06),
        .CORE_COUNT(8'h02), .LINKS_PER_PROC(8'h03)) uut (
        .clk, .rst_n, .boot_select_pin_a, .boot_select_pin_b,
        .cfg_rd, .cfg_wr, .cfg_num, .cfg_wdata, .cfg_rdata_q,
        .cfg_rvalid_q, .cfg_wack_q, .cfg_werr_q, .one_byte_headers,
        .pll_locked, .route_id, .pll_settings,
        .pll_write_pulse_q(pll_wr_pulse), .switch_clock_div(sw_div),
        .reference_clock_div(ref_div), .route_directions,
        .debug_pin_cfg(dbg_cfg));
    sncr_cfg_requester req (.clk, .cfg_rd, .cfg_wr, .cfg_num, .cfg_wdata,
        .cfg_rdata_q, .cfg_rvalid_q, .cfg_wack_q, .cfg_werr_q);
    ////////////////////
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("Error at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] n, input [31:0] d);
        req.xfer(1'b1, n, d, q, e);
    endtask
    task rd(input [7:0] n, input [31:0] x);
        begin
            req.xfer(1'b0, n, 32'h0, q, e);
            chk(q, x);
        end
    endtask
    task do_reset;
        begin
            @(posedge clk);
            rst_n <= 1'b0;
            repeat (5) @(posedge clk);
            rst_n <= 1'b1;
        end
    endtask
    task finish_test;
        begin
            if (errors == 0 && checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task t_ids;
        begin
            rd(8'h00, 32'h3C010101);
            @(posedge clk);
            boot_select_pin_a <= 1'b0;
            boot_select_pin_b <= 1'b1;
            wr(8'h00, 32'hFFFFFFFF);
            rd(8'h00, 32'h3C010101);
            wr(8'h01, 32'hFFFFFFFF);
            rd(8'h01, 32'h00060203);
            rd(8'h04, 32'h0);
            rd(8'h08, 32'h3);
            chk({16'h0, ref_div}, 32'h3);
        end
    endtask
    task t_fields;
        begin
            wr(8'h05, 32'hFFFFABCD);
            rd(8'h05, 32'h0000ABCD);
            chk({16'h0, route_id}, 32'hABCD);
            wr(8'h0C, 32'h12345678);
            wr(8'h0D, 32'h9ABCDEF0);
            chk(route_directions[63:32], 32'h9ABCDEF0);
            rd(8'h0C, 32'h12345678);
            rd(8'h30, 32'h0);
            wr(8'h07, 32'hFFFF1357);
            chk({16'h0, sw_div}, 32'h1357);
            wr(8'h10, 32'hFFFFFFFE);
            chk({30'h0, dbg_cfg}, 32'h2);
            wr(8'h04, 32'h7FFFFEFE);
            rd(8'h04, 32'h0);
        end
    endtask
    task t_pll;
        begin
            wr(8'h06, 32'hFFFFFFFF);
            chk({31'h0, pll_wr_pulse}, 32'h1);
            rd(8'h06, 32'h039FFF7F);
            wr(8'h04, 32'h101);
            chk({31'h0, one_byte_headers}, 32'h1);
            wr(8'h06, 32'h0);
            chk({31'h0, e}, 32'h0);
            chk({31'h0, pll_wr_pulse}, 32'h0);
            rd(8'h06, 32'h039FFF7F);
            wr(8'h04, 32'h0);
            wr(8'h06, 32'h0);
            rd(8'h06, 32'h0);
        end
    endtask
    task t_lock;
        begin
            wr(8'h04, 32'h80000000);
            wr(8'h05, 32'h1234);
            chk({31'h0, e}, 32'h1);
            wr(8'h04, 32'h0);
            chk({31'h0, e}, 32'h1);
            rd(8'h04, 32'h80000000);
            rd(8'h05, 32'h0000ABCD);
            do_reset;
            rd(8'h00, 32'h3C020101);
            wr(8'h05, 32'h1234);
            rd(8'h05, 32'h1234);
        end
    endtask
    initial begin
        do_reset;
        t_ids;
        t_fields;
        t_pll;
        t_lock;
        finish_test;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            errors = errors + 1;
            finish_test;
        end
    end
endmodule // switch_node_config_regs_tb_top
bind sncr_node_regs sncr_chk u_chk (.clk, .rst_n, .cfg_rd, .cfg_wr,
    .cfg_num, .cfg_rdata_q, .cfg_rvalid_q, .cfg_wack_q, .cfg_werr_q,
    .one_byte_headers, .pll_locked, .route_id, .pll_settings);
